// *** rtl/clock_mode_selection.sv ***
// clock mode decode, pin roles, multiplier gating and divided clocks
// assumes apb master on clock; internal oscillator ticks arrive as enables
//
// Overview of operation
// - crystal modes use both oscillator pins as resonator
// - high speed crystal also accepts external clock
// - external clock modes: input pin, no startup delay
// - external clock out mode drives clock/4 out
// - external clock pin mode: out pin is gpio6, output only; port_a_bit6_pin_in held at 0
// - resistor capacitor mode drives clock/4 out
// - resistor capacitor pin mode: out pin gpio6, output only; port_a_bit6_pin_in held at 0
// - x4 mode multiplies high speed oscillator by four
// - crystal multiplier only with mode code 0110
// - x4 mode ignores software multiplier enable bit
// - software may multiply fast internal oscillator
// - fast oscillator direct or through postscaler
// - fast oscillator enabled for 125k to 8M
// - slow oscillator on when chosen or needed
// - frequency choice picks fast, slow or postscaler
// - clkout mode: out clock/4, in pin gpio7
// - dual pin mode: both pins general io; gpio6 is output only, port_a_bit6_pin_in held at 0
// - trim settles: slow 8 cycles, fast 1 ms
// - no completion flag for retune settling
// - origin bit picks 31 kHz source
// - trim register multiplier bit drives multiplier
// - four-bit field decodes ten clock modes
// - internal multiplier needs mode 1001/1000, freq 11x
// - unavailable multiplier bit reads as zero
// - origin set: fast/256; clear: slow direct
//
// Local design decisions: the placing of the registers and the APB register port.
`include "clock_mode_selection_regs.svh"

module clock_mode_selection
  import clock_mode_selection_pkg::*;
#(
  parameter int unsigned FAST_SETTLE = `FAST_SETTLE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator ticks, one-cycle enables
  input wire logic primary_tick,
  input wire logic fast_tick,
  input wire logic slow_tick,
  // oscillator pins
  input wire logic oscillator_in_pin_i,
  output logic oscillator_out_pin_o,
  output logic oscillator_out_pin_oe_n,
  // port a bits 6 and 7 from the io port
  input wire logic port_a_bit6_pin_out,
  input wire logic port_a_bit6_pin_oe_n,
  input wire logic port_a_bit7_pin_out,
  input wire logic port_a_bit7_pin_oe_n,
  output logic oscillator_in_pin_o,
  output logic oscillator_in_pin_oe_n,
  output logic port_a_bit6_pin_in,
  output logic port_a_bit7_pin_in,
  // clock control outputs
  output logic device_clk_tick,
  output logic resonator_en,
  output logic startup_delay_en,
  output logic crystal_mult_en,
  output logic internal_mult_en,
  output logic fast_osc_en,
  output logic slow_osc_en,
  output logic [4:0] fast_trim,
  output logic [4:0] slow_trim
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_internal(input logic [3:0] m);
    is_internal = (m == internal_osc_clkout_mode) || (m == internal_osc_dual_pin_mode);
  endfunction : is_internal

  function automatic logic is_external(input logic [3:0] m);
    is_external = (m == external_clock_out_mode) || (m == external_clock_pin_mode);
  endfunction : is_external

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [3:0] oscillator_mode_config_q;
  logic [7:0] oscillator_trim_register_q;
  logic [11:0] oscillator_control_register_q;
  logic [2:0] internal_freq_choice;
  logic low_freq_origin_choice;
  logic multiplier_enable;
  logic mult_allowed;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign addr_ok = (paddr == `OFS_MODE_CONFIG) || (paddr == `OFS_TRIM) ||
                   (paddr == `OFS_CONTROL) || (paddr == `OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  assign internal_freq_choice =
    oscillator_control_register_q[`CTRL_FREQ_MSB:`CTRL_FREQ_LSB];
  assign low_freq_origin_choice = oscillator_trim_register_q[`TRIM_ORIGIN_BIT];

  // unknown codes fall back to the resistor capacitor pin mode
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      oscillator_mode_config_q <= `MODE_RESET;
    end else if (apb_wr && paddr == `OFS_MODE_CONFIG) begin
      case (pwdata[3:0])
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9: begin
          oscillator_mode_config_q <= pwdata[3:0];
        end
        default: begin
          oscillator_mode_config_q <= `MODE_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      oscillator_trim_register_q <= `TRIM_RESET;
    end else if (apb_wr && paddr == `OFS_TRIM) begin
      oscillator_trim_register_q <= {pwdata[7:6], 1'b0, pwdata[4:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      oscillator_control_register_q <= `CTRL_RESET;
    end else if (apb_wr && paddr == `OFS_CONTROL) begin
      oscillator_control_register_q <= pwdata[11:0];
    end
  end

  // ----------------------------------------
  // multiplier gating
  // ----------------------------------------
  assign mult_allowed = is_internal(oscillator_mode_config_q) &&
    (internal_freq_choice == `FREQ_8M || internal_freq_choice == `FREQ_4M);
  assign multiplier_enable = oscillator_trim_register_q[`TRIM_MULT_BIT] && mult_allowed;
  assign internal_mult_en = multiplier_enable;
  // software bit plays no part here
  assign crystal_mult_en = (oscillator_mode_config_q == high_speed_crystal_x4_mode);

  // ----------------------------------------
  // source choice and oscillator enables
  // ----------------------------------------
  clk_src_t src;
  always_comb begin
    if (!is_internal(oscillator_mode_config_q)) begin
      src = src_primary;
    end else if (internal_freq_choice == `FREQ_LOW && !low_freq_origin_choice) begin
      src = src_slow;
    end else begin
      src = src_fast;
    end
  end

  // also runs when it feeds the divide-by-256 low clock
  assign fast_osc_en = (src == src_fast);
  assign slow_osc_en = (src == src_slow) ||
    oscillator_control_register_q[`CTRL_PWRT_BIT] ||
    oscillator_control_register_q[`CTRL_FSCM_BIT] ||
    oscillator_control_register_q[`CTRL_WDT_BIT] ||
    oscillator_control_register_q[`CTRL_TWOSPD_BIT];

  // ----------------------------------------
  // postscaler: 8M >> (7 - choice), low code divides by 256
  // ----------------------------------------
  logic [7:0] post_cnt_q;
  logic post_tick;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      post_cnt_q <= 8'h00;
    end else if (fast_tick) begin
      post_cnt_q <= post_cnt_q + 8'h01;
    end
  end

  always_comb begin
    case (internal_freq_choice)
      3'h7: post_tick = fast_tick;
      3'h6: post_tick = fast_tick && post_cnt_q[0];
      3'h5: post_tick = fast_tick && (&post_cnt_q[1:0]);
      3'h4: post_tick = fast_tick && (&post_cnt_q[2:0]);
      3'h3: post_tick = fast_tick && (&post_cnt_q[3:0]);
      3'h2: post_tick = fast_tick && (&post_cnt_q[4:0]);
      3'h1: post_tick = fast_tick && (&post_cnt_q[5:0]);
      default: post_tick = fast_tick && (&post_cnt_q);
    endcase
  end

  always_comb begin
    case (src)
      src_slow: device_clk_tick = slow_tick;
      src_fast: device_clk_tick = post_tick;
      src_primary: device_clk_tick = primary_tick;
      default: device_clk_tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // clock/4 output
  // ----------------------------------------
  logic [1:0] div_cnt_q;
  logic clk_div4_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      div_cnt_q <= 2'h0;
      clk_div4_q <= 1'b0;
    end else if (device_clk_tick) begin
      div_cnt_q <= div_cnt_q + 2'h1;
      if (div_cnt_q[0]) begin
        clk_div4_q <= ~clk_div4_q;
      end
    end
  end

  // ----------------------------------------
  // pin roles
  // ----------------------------------------
  pin_role_t in_role;
  pin_role_t out_role;
  always_comb begin
    case (osc_mode_t'(oscillator_mode_config_q))
      low_power_crystal_mode, crystal_standard_mode, high_speed_crystal_x4_mode: begin
        in_role = pin_resonator;
        out_role = pin_resonator;
      end
      high_speed_crystal_mode: begin
        in_role = pin_resonator;
        out_role = pin_resonator;
      end
      external_clock_out_mode: begin
        in_role = pin_clock_in;
        out_role = pin_clock_out;
      end
      external_clock_pin_mode: begin
        in_role = pin_clock_in;
        out_role = pin_gpio;
      end
      resistor_capacitor_mode: begin
        in_role = pin_resonator;
        out_role = pin_clock_out;
      end
      resistor_capacitor_pin_mode: begin
        in_role = pin_resonator;
        out_role = pin_gpio;
      end
      internal_osc_clkout_mode: begin
        in_role = pin_gpio;
        out_role = pin_clock_out;
      end
      internal_osc_dual_pin_mode: begin
        in_role = pin_gpio;
        out_role = pin_gpio;
      end
      default: begin
        in_role = pin_resonator;
        out_role = pin_gpio;
      end
    endcase
  end

  assign resonator_en = (out_role == pin_resonator);
  assign startup_delay_en = !is_external(oscillator_mode_config_q);

  always_comb begin
    case (out_role)
      pin_clock_out: begin
        oscillator_out_pin_o = clk_div4_q;
        oscillator_out_pin_oe_n = 1'b0;
      end
      pin_gpio: begin
        oscillator_out_pin_o = port_a_bit6_pin_out;
        oscillator_out_pin_oe_n = port_a_bit6_pin_oe_n;
      end
      default: begin
        oscillator_out_pin_o = 1'b0;
        oscillator_out_pin_oe_n = 1'b1;
      end
    endcase
  end

  assign oscillator_in_pin_o = (in_role == pin_gpio) ? port_a_bit7_pin_out : 1'b0;
  assign oscillator_in_pin_oe_n = (in_role == pin_gpio) ? port_a_bit7_pin_oe_n : 1'b1;
  assign port_a_bit7_pin_in = (in_role == pin_gpio) ? oscillator_in_pin_i : 1'b0;
  assign port_a_bit6_pin_in = 1'b0;

  // ----------------------------------------
  // trim settling, no status exposed
  // ----------------------------------------
  logic [31:0] fast_settle_q;
  logic [3:0] slow_settle_q;
  logic trim_wr;
  assign trim_wr = apb_wr && paddr == `OFS_TRIM;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fast_settle_q <= 32'h0000_0000;
      fast_trim <= 5'h00;
    end else if (trim_wr) begin
      fast_settle_q <= FAST_SETTLE;
    end else if (fast_settle_q != 32'h0000_0000) begin
      fast_settle_q <= fast_settle_q - 32'h0000_0001;
      if (fast_settle_q == 32'h0000_0001) begin
        fast_trim <= oscillator_trim_register_q[`TRIM_TUNE_MSB:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      slow_settle_q <= 4'h0;
      slow_trim <= 5'h00;
    end else if (trim_wr) begin
      slow_settle_q <= 4'(`SLOW_SETTLE_CYC);
    end else if (slow_tick && slow_settle_q != 4'h0) begin
      slow_settle_q <= slow_settle_q - 4'h1;
      if (slow_settle_q == 4'h1) begin
        slow_trim <= oscillator_trim_register_q[`TRIM_TUNE_MSB:0];
      end
    end
  end

  // ----------------------------------------
  // read data, settle state never shown
  // ----------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_rd) begin
      case (paddr)
        `OFS_MODE_CONFIG: prdata = {28'h000_0000, oscillator_mode_config_q};
        `OFS_TRIM: prdata = {24'h00_0000, low_freq_origin_choice, multiplier_enable,
                             oscillator_trim_register_q[5:0]};
        `OFS_CONTROL: prdata = {20'h0_0000, oscillator_control_register_q};
        `OFS_STATUS: prdata = {26'h000_0000, fast_osc_en, slow_osc_en,
                               crystal_mult_en, internal_mult_en,
                               startup_delay_en, resonator_en};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : clock_mode_selection

// *** rtl/clock_mode_selection_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with word-aligned registers
`ifndef CLOCK_MODE_SELECTION_REGS_SVH
`define CLOCK_MODE_SELECTION_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_MODE_CONFIG 12'h000
`define OFS_TRIM 12'h004
`define OFS_CONTROL 12'h008
`define OFS_STATUS 12'h00C

// ----------------------------------------
// trim register fields
// ----------------------------------------
`define TRIM_ORIGIN_BIT 7
`define TRIM_MULT_BIT 6
`define TRIM_TUNE_MSB 4
`define TRIM_RESET 8'h00

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_FREQ_LSB 4
`define CTRL_FREQ_MSB 6
`define CTRL_PWRT_BIT 8
`define CTRL_FSCM_BIT 9
`define CTRL_WDT_BIT 10
`define CTRL_TWOSPD_BIT 11
`define CTRL_RESET 12'h000
`define MODE_RESET 4'h7

// ----------------------------------------
// frequency choice codes
// ----------------------------------------
`define FREQ_LOW 3'h0
`define FREQ_4M 3'h6
`define FREQ_8M 3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 250
`define FAST_SETTLE_US 1000
`define FAST_SETTLE_CYC (`FAST_SETTLE_US * `CLK_MHZ)
`define SLOW_SETTLE_CYC 8
`define POST_DIV 256
`define OUT_DIV 4

`endif

// *** rtl/clock_mode_selection_pkg.sv ***
// types for the clock mode selection block
// assumes nothing beyond a systemverilog tool
package clock_mode_selection_pkg;

  typedef enum logic [3:0] {
    low_power_crystal_mode = 4'h0,
    crystal_standard_mode = 4'h1,
    high_speed_crystal_mode = 4'h2,
    high_speed_crystal_x4_mode = 4'h6,
    resistor_capacitor_mode = 4'h3,
    resistor_capacitor_pin_mode = 4'h7,
    internal_osc_clkout_mode = 4'h9,
    internal_osc_dual_pin_mode = 4'h8,
    external_clock_out_mode = 4'h4,
    external_clock_pin_mode = 4'h5
  } osc_mode_t;

  typedef enum logic [2:0] {
    src_primary = 3'b001,
    src_fast = 3'b010,
    src_slow = 3'b100
  } clk_src_t;

  typedef enum logic [1:0] {
    pin_resonator = 2'h0,
    pin_clock_in = 2'h1,
    pin_clock_out = 2'h2,
    pin_gpio = 2'h3
  } pin_role_t;

endpackage : clock_mode_selection_pkg

// *** test/clock_mode_selection_properties.sv ***
// port checks for the clock mode selection block
// assumes binding onto the design top; apb writes are shadowed here
module clock_mode_selection_properties (
  // clock, reset and apb
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // pins
  input wire logic oscillator_in_pin_i,
  input wire logic oscillator_out_pin_oe_n,
  input wire logic oscillator_in_pin_oe_n,
  input wire logic port_a_bit6_pin_oe_n,
  input wire logic port_a_bit7_pin_oe_n,
  input wire logic port_a_bit7_pin_in,
  // clock control
  input wire logic resonator_en,
  input wire logic startup_delay_en,
  input wire logic crystal_mult_en,
  input wire logic internal_mult_en,
  input wire logic fast_osc_en,
  input wire logic slow_osc_en
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] RES_M = 10'h047;
  localparam logic [9:0] EXT_M = 10'h030;
  localparam logic [9:0] DRV_M = 10'h218;
  localparam logic [9:0] GPO_M = 10'h1a0;
  logic [3:0] mode_q;
  logic [11:0] ctl_q;
  logic mult_q;
  // ----------------
  // register shadow
  // ----------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_q <= 4'h7;
      ctl_q <= 12'h000;
      mult_q <= 1'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == 12'h000) mode_q <= (pwdata[3:0] > 4'h9) ? 4'h7 : pwdata[3:0];
      if (paddr == 12'h008) ctl_q <= pwdata[11:0];
      if (paddr == 12'h004) mult_q <= pwdata[6];
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence x4_write_s;
    psel && penable && pwrite && paddr == 12'h000 && pwdata[3:0] == 4'h6;
  endsequence
  AST_RESONATOR: assert property (resonator_en == RES_M[mode_q])
    else $error("resonator role wrong");
  AST_NO_STARTUP: assert property (EXT_M[mode_q] |-> !startup_delay_en)
    else $error("startup delay in external mode");
  AST_XTAL_MULT: assert property (crystal_mult_en == (mode_q == 4'h6))
    else $error("crystal multiplier gate wrong");
  AST_X4_WRITE: assert property (x4_write_s |=> crystal_mult_en [*2])
    else $error("x4 mode write did not enable multiplier");
  AST_INT_MULT: assert property (internal_mult_en ==
    (mult_q && mode_q[3:1] == 3'h4 && ctl_q[6:5] == 2'h3))
    else $error("internal multiplier gate wrong");
  AST_SLOW_AUTO: assert property (|ctl_q[11:8] |-> slow_osc_en)
    else $error("slow oscillator not enabled");
  AST_FAST_ON: assert property (mode_q[3:1] == 3'h4 && ctl_q[6:4] != 3'h0 |->
    fast_osc_en)
    else $error("fast oscillator not enabled");
  AST_OUT_DRIVE: assert property (DRV_M[mode_q] |-> !oscillator_out_pin_oe_n)
    else $error("out pin not driven");
  AST_OUT_GPIO: assert property (GPO_M[mode_q] |->
    oscillator_out_pin_oe_n == port_a_bit6_pin_oe_n)
    else $error("out pin not general io");
  AST_IN_GPIO: assert property (mode_q[3:1] == 3'h4 |-> port_a_bit7_pin_in ==
    oscillator_in_pin_i && oscillator_in_pin_oe_n == port_a_bit7_pin_oe_n)
    else $error("in pin not general io");
endmodule : clock_mode_selection_properties

bind clock_mode_selection clock_mode_selection_properties props_inst (.*);

// *** test/osc_source_model.sv ***
// oscillator sources outside the block: external clock and ticks
// assumes the bench clock; all outputs change just after rising edges
module osc_source_model (
  // bench clock
  input wire logic clock,
  // oscillator sources
  output logic primary_tick,
  output logic fast_tick,
  output logic slow_tick,
  output logic oscillator_in_pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge clock) begin
    cnt <= cnt + 1;
    primary_tick <= (cnt % 3) == 0;
    fast_tick <= (cnt % 2) == 0;
    slow_tick <= (cnt % 8) == 0;
    oscillator_in_pin_i <= (cnt % 6) < 3;
  end
endmodule : osc_source_model

// *** test/tb.sv ***
// self-checking bench for the clock mode selection block
// assumes osc_source_model for the ticks; checker bound in its own file
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] RES_M = 10'h047;
  localparam logic [9:0] EXT_M = 10'h030;
  localparam logic [9:0] DRV_M = 10'h218;
  localparam logic [9:0] GPO_M = 10'h1a0;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic port_a_bit6_pin_out = 1'h1;
  logic port_a_bit6_pin_oe_n = 1'h0;
  logic port_a_bit7_pin_out = 1'h1;
  logic port_a_bit7_pin_oe_n = 1'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, primary_tick, fast_tick, slow_tick, oscillator_in_pin_i;
  logic oscillator_out_pin_o, oscillator_out_pin_oe_n, oscillator_in_pin_o;
  logic oscillator_in_pin_oe_n, port_a_bit6_pin_in, port_a_bit7_pin_in, device_clk_tick;
  logic resonator_en, startup_delay_en, crystal_mult_en, internal_mult_en;
  logic fast_osc_en, slow_osc_en;
  logic [4:0] fast_trim, slow_trim;
  int miscompares = 0;
  int n_tests = 0;
  int dev, slw, flp, tf, ts, e;
  initial begin
    forever #2 clock = ~clock;
  end
  clock_mode_selection #(.FAST_SETTLE(20)) clock_mode_selection_inst (.*);
  osc_source_model osc_source_model_inst (.*);
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one apb transfer, then an idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'h1 && i < 50);
    if (i >= 50) begin
      miscompares++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb
  task automatic count(input int n);
    logic prev;
    prev = oscillator_out_pin_o;
    dev = 0;
    slw = 0;
    flp = 0;
    repeat (n) begin
      @(posedge clock);
      dev += (device_clk_tick === 1'h1);
      slw += (slow_tick === 1'h1);
      flp += (oscillator_out_pin_o !== prev);
      prev = oscillator_out_pin_o;
    end
  endtask : count
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'h1;
    @(posedge clock);
    apb(1'h0, 12'h000, 32'h0000_0000);
    check("mode reset", rd, 32'h0000_0007);
    apb(1'h0, 12'h004, 32'h0000_0000);
    check("trim reset", rd, 32'h0000_0000);
    $display("test reset done");
    for (int m = 0; m < 11; m++) begin
      e = (m > 9) ? 7 : m;
      apb(1'h1, 12'h000, 32'(m));
      apb(1'h0, 12'h000, 32'h0000_0000);
      check("mode", rd, 32'(e));
      check("resonator", resonator_en, RES_M[e]);
      check("crystal mult", crystal_mult_en, e == 6);
      check("startup", startup_delay_en, !EXT_M[e]);
      if (DRV_M[e]) check("out drive", oscillator_out_pin_oe_n, 1'h0);
      if (GPO_M[e]) check("out gpio", {oscillator_out_pin_o, oscillator_out_pin_oe_n}, 2'h2);
      if (e > 7) check("in gpio", port_a_bit7_pin_in, oscillator_in_pin_i);
      check("in pin drive", {oscillator_in_pin_o, oscillator_in_pin_oe_n}, (e > 7) ? 2'h2 : 2'h1);
    end
    $display("test mode decode done");
    apb(1'h1, 12'h008, 32'h0000_0070);
    for (int m = 3; m < 10; m++) begin
      if (DRV_M[m]) begin
        apb(1'h1, 12'h000, 32'(m));
        count(200);
        check("divide by four", (dev - 2 * flp) inside {[-2:2]} && dev > 20, 1'h1);
      end
    end
    $display("test clock out done");
    apb(1'h1, 12'h004, 32'h0000_0040);
    check("internal mult", internal_mult_en, 1'h1);
    apb(1'h0, 12'h00C, 32'h0000_0000);
    check("status mult", rd[3:2], 2'h1);
    apb(1'h1, 12'h008, 32'h0000_0050);
    check("mult freq gate", internal_mult_en, 1'h0);
    apb(1'h1, 12'h008, 32'h0000_0070);
    apb(1'h1, 12'h000, 32'h0000_0006);
    check("x4 mode", {crystal_mult_en, internal_mult_en}, 2'h2);
    apb(1'h0, 12'h004, 32'h0000_0000);
    check("mult reads zero", rd, 32'h0000_0000);
    $display("test multiplier done");
    apb(1'h1, 12'h000, 32'h0000_0009);
    for (int k = 1; k < 8; k++) begin
      apb(1'h1, 12'h008, 32'(k << 4));
      check("fast osc on", fast_osc_en, 1'h1);
    end
    for (int b = 8; b < 12; b++) begin
      apb(1'h1, 12'h008, 32'(1 << b));
      check("slow osc auto", slow_osc_en, 1'h1);
    end
    apb(1'h1, 12'h008, 32'h0000_0000);
    apb(1'h1, 12'h004, 32'h0000_0000);
    check("slow chosen", slow_osc_en, 1'h1);
    count(200);
    check("slow source", dev, slw);
    apb(1'h1, 12'h004, 32'h0000_0080);
    count(1100);
    check("fast div 256", dev inside {2, 3}, 1'h1);
    check("fast osc origin", fast_osc_en, 1'h1);
    $display("test sources done");
    apb(1'h1, 12'h004, 32'h0000_0005);
    tf = 0;
    ts = 0;
    for (int c = 1; c <= 120; c++) begin
      @(posedge clock);
      if (tf == 0 && fast_trim === 5'h05) tf = c;
      if (ts == 0 && slow_trim === 5'h05) ts = c;
    end
    check("fast settle", tf > 14 && tf < 26, 1'h1);
    check("slow settle", ts > 48 && ts < 76, 1'h1);
    $display("test trim settle done");
    apb(1'h1, 12'h010, 32'hFFFF_FFFF);
    check("unmapped write", err, 1'h1);
    apb(1'h0, 12'h010, 32'h0000_0000);
    check("unmapped read", rd, 32'h0000_0000);
    apb(1'h0, 12'h000, 32'h0000_0000);
    check("mode kept", rd, 32'h0000_0009);
    $display("test unmapped done");
    finish_test();
  end
endmodule : tb
